// [common/pmrc_cfg.svh]
// Constants for the paging message rule checker
`ifndef PMRC_CFG_SVH
`define PMRC_CFG_SVH
`define PMRC_CLK_HZ 50000000
`define PMRC_TICK_HZ 1000
`define PMRC_SEC_PER_MIN 60
`define PMRC_FRAG_HOLD_MIN 4
`define PMRC_TICK_W 16
`define PMRC_HOLD_W 18
`define PMRC_AW 3
`define PMRC_NADDR 8
`define PMRC_NW 6
`define PMRC_SUM_W 16
`define PMRC_REG_CTRL 8'h00
`define PMRC_REG_STAT 8'h04
`define PMRC_REG_CHK 8'h08
`define PMRC_CTRL_W 9
`define PMRC_CTRL_RST 9'h0FF
`define PMRC_C_MAX 5:0
`define PMRC_C_NUM 6
`define PMRC_C_ALPHA 7
`define PMRC_C_ANYPH 8
`define PMRC_S_MISS 12
`define PMRC_S_FERR 13
`define PMRC_S_KERR 14
`define PMRC_S_ABAN 15
`define PMRC_H_K 9:0
`define PMRC_H_C 10
`define PMRC_H_F 12:11
`define PMRC_H_N 18:13
`define PMRC_K_MASK 21'h1F_FC00
`define PMRC_G0 7:0
`define PMRC_G1 15:8
`define PMRC_G2 20:16
`define PMRC_CH_W 7
`define PMRC_CH_N 3
`define PMRC_ETX 7'h03
`define PMRC_F_INIT 2'b11
`define PMRC_F_LAST 2'b10
`define PMRC_F_FIRST 2'b00
`define PMRC_F_STEP 2'b01
`define PMRC_V_SECURE 3'b000
`define PMRC_V_SHORTI 3'b001
`define PMRC_V_SHORT 3'b010
`define PMRC_V_NUM 3'b011
`define PMRC_V_SNUM 3'b100
`define PMRC_V_ALPHA 3'b101
`define PMRC_V_NNUM 3'b111
`define PMRC_T_NORM 2'b00
`define PMRC_I_NORM 3'b000
`endif

// [common/pmrc_pkg.sv]
// Types for the paging message rule checker
package pmrc_pkg;
  typedef enum logic [1:0] {
    PMRC_IDLE = 2'b00,
    PMRC_BODY = 2'b01,
    PMRC_SKIP = 2'b11
  } pmrc_state_t;
  typedef enum logic [1:0] {
    PMRC_R1600_2L = 2'b00,
    PMRC_R3200_2L = 2'b01,
    PMRC_R3200_4L = 2'b10,
    PMRC_R6400_4L = 2'b11
  } pmrc_rate_t;
endpackage

// [hdl/pmrc_msgnum_tbl.sv]
// Per-address message number memory and missed-message detector
`include "pmrc_cfg.svh"
module pmrc_msgnum_tbl (
  input logic clock,
  input logic reset,
  input logic chk_valid,
  input logic [`PMRC_AW-1:0] chk_addr,
  input logic [`PMRC_NW-1:0] chk_num,
  input logic chk_skip,
  input logic [`PMRC_NW-1:0] roll_max,
  output logic missed,
  output logic [`PMRC_NW-1:0] miss_first,
  output logic [`PMRC_NW-1:0] miss_count
);
  logic [`PMRC_NW-1:0] last_ff [0:`PMRC_NADDR-1];
  logic [`PMRC_NADDR-1:0] seen_ff;
  wire [`PMRC_NW-1:0] last_num = last_ff[chk_addr];
  wire [`PMRC_NW-1:0] exp_num = (last_num >= roll_max) ? '0 : last_num + 6'h01;
  wire [`PMRC_NW:0] modulus = {1'b0, roll_max} + 7'h01;
  wire [`PMRC_NW:0] gap = (chk_num >= exp_num) ? {1'b0, chk_num} - {1'b0, exp_num}
                          : {1'b0, chk_num} + modulus - {1'b0, exp_num};
  wire take = chk_valid & ~chk_skip;
  wire is_miss = take & seen_ff[chk_addr] & (chk_num != exp_num);

  always_ff @(posedge clock) begin
    if (take) begin
      last_ff[chk_addr] <= chk_num;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      seen_ff <= '0;
      missed <= 1'b0;
      miss_first <= '0;
      miss_count <= '0;
    end else begin
      missed <= is_miss;
      if (take) begin
        seen_ff[chk_addr] <= 1'b1;
      end
      if (is_miss) begin
        miss_first <= exp_num;
        miss_count <= gap[`PMRC_NW-1:0];
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  miss_report_a: assert property (is_miss |=> missed && miss_first == $past(exp_num))
    else $error("missed number not reported");
  skip_no_miss_a: assert property (chk_valid && chk_skip |=> !missed)
    else $error("unnumbered message raised a miss");
endmodule

// [hdl/pmrc_frag_sum.sv]
// Fragment check sum accumulator
`include "pmrc_cfg.svh"
module pmrc_frag_sum (
  input logic clock,
  input logic reset,
  input logic sum_valid,
  input logic sum_first,
  input logic [20:0] sum_word,
  output logic [9:0] chk_value
);
  logic [`PMRC_SUM_W-1:0] acc_ff;
  wire [20:0] eff = sum_first ? (sum_word & `PMRC_K_MASK) : sum_word;
  wire [`PMRC_SUM_W-1:0] grp = `PMRC_SUM_W'(eff[`PMRC_G0]) + `PMRC_SUM_W'(eff[`PMRC_G1])
                               + `PMRC_SUM_W'(eff[`PMRC_G2]);
  wire [`PMRC_SUM_W-1:0] nxt_acc = (sum_first ? '0 : acc_ff) + grp;

  always_ff @(posedge clock) begin
    if (reset) begin
      acc_ff <= '0;
    end else if (sum_valid) begin
      acc_ff <= nxt_acc;
    end
  end

  assign chk_value = ~acc_ff[9:0];

  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sum_restart_a: assert property (sum_valid && sum_first |=> acc_ff == $past(grp))
    else $error("check sum did not restart");
  sum_hold_a: assert property (!sum_valid |=> $stable(acc_ff))
    else $error("check sum moved without a word");
endmodule

// [hdl/pmrc_msg_checker.sv]
// Paging message word checker: header decode, fragments, numbering, registers
`include "pmrc_cfg.svh"
// ----------------------------------------
// Behaviour
// - Rollover maximum comes from a software written configuration field.
// - Out of order number flags a miss and gives the missing numbers.
// - Messages with retrieval flag 0 skip miss check and numbering.
// - Message number ties fragments of one message together.
// - Spare header bits are ignored by the decoder.
// - After the header word every 7-bit field is one ASCII character.
// - Open fragmented message is kept at least four minutes.
// - Dynamic group messages get no miss tracking.
// - Numeric support also accepts short message vector type 00.
// - Alpha support accepts numeric, short, and any-phase instruction 000.
// - All four rate and modulation modes are decoded.
// - Continued flag set means more fragments; clear means final.
// - Fragment number starts at 11, then counts modulo 3.
// - Check is ones complement of group sums, ten low bits.
// ----------------------------------------
module pmrc_msg_checker #(
  parameter int TICK_CYCLES = `PMRC_CLK_HZ / `PMRC_TICK_HZ,
  parameter int HOLD_TICKS = `PMRC_FRAG_HOLD_MIN * `PMRC_SEC_PER_MIN * `PMRC_TICK_HZ
) (
  input logic clock,
  input logic reset,
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  input logic word_valid,
  input logic [20:0] word_data,
  input logic word_first,
  input logic word_last,
  input logic [`PMRC_AW-1:0] msg_addr,
  input logic [2:0] vector_type_code,
  input logic [1:0] short_msg_type,
  input logic [2:0] instruction_type,
  input logic msg_retrieval,
  input logic msg_dyn_group,
  input logic [`PMRC_NW-1:0] num_field,
  input logic [1:0] rate_mode,
  output logic char_valid,
  output logic [20:0] char_data,
  output logic [`PMRC_CH_N-1:0] char_keep,
  output logic msg_accept,
  output logic msg_reject,
  output logic msg_done,
  output logic missed_pulse,
  output logic frag_err,
  output logic check_err,
  output logic frag_abandon
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  pmrc_pkg::pmrc_state_t state_ff;
  pmrc_pkg::pmrc_state_t nxt_state;
  pmrc_pkg::pmrc_rate_t rate_ff;
  logic [`PMRC_CTRL_W-1:0] ctrl_ff;
  logic text_ff;
  logic open_ff;
  logic [`PMRC_AW-1:0] open_addr_ff;
  logic [`PMRC_NW-1:0] open_num_ff;
  logic [1:0] exp_frag_ff;
  logic [`PMRC_TICK_W-1:0] tick_cnt_ff;
  logic [`PMRC_HOLD_W-1:0] hold_cnt_ff;
  logic [9:0] k_ff;
  logic chk_pend_ff;
  logic etx_seen_ff;
  logic miss_s_ff;
  logic ferr_s_ff;
  logic kerr_s_ff;
  logic aban_s_ff;
  logic [`PMRC_NW-1:0] miss_first;
  logic [`PMRC_NW-1:0] miss_count;
  logic [9:0] chk_value;

  // ----------------------------------------
  // Vector acceptance
  // ----------------------------------------
  wire sup_num = ctrl_ff[`PMRC_C_NUM];
  wire sup_alpha = ctrl_ff[`PMRC_C_ALPHA];
  wire any_phase = ctrl_ff[`PMRC_C_ANYPH];
  wire v_numeric = (vector_type_code == `PMRC_V_NUM) | (vector_type_code == `PMRC_V_SNUM)
                   | (vector_type_code == `PMRC_V_NNUM);
  wire acc_num = v_numeric & (sup_num | sup_alpha);
  wire acc_short = (vector_type_code == `PMRC_V_SHORT) & (short_msg_type == `PMRC_T_NORM)
                   & (sup_num | sup_alpha);
  wire acc_instr = (vector_type_code == `PMRC_V_SHORTI) & (instruction_type == `PMRC_I_NORM)
                   & sup_alpha & any_phase;
  wire acc_text = ((vector_type_code == `PMRC_V_ALPHA) | (vector_type_code == `PMRC_V_SECURE))
                  & sup_alpha;
  wire accept = acc_num | acc_short | acc_instr | acc_text;
  wire start = word_valid & word_first;
  wire hdr_start = start & acc_text;

  // ----------------------------------------
  // Header fields
  // ----------------------------------------
  // spare bits left unread
  wire [1:0] h_frag = word_data[`PMRC_H_F];
  wire h_cont = word_data[`PMRC_H_C];
  wire [`PMRC_NW-1:0] h_num = word_data[`PMRC_H_N];
  wire frag_init = h_frag == `PMRC_F_INIT;
  wire frag_match = open_ff & (msg_addr == open_addr_ff) & (h_num == open_num_ff)
                    & (h_frag == exp_frag_ff);
  wire frag_bad = hdr_start & ~frag_init & ~frag_match;
  wire [1:0] frag_next = (frag_init | (h_frag == `PMRC_F_LAST)) ? `PMRC_F_FIRST
                         : h_frag + `PMRC_F_STEP;
  wire frag_upd = hdr_start & h_cont & (frag_init | frag_match);
  wire frag_end = hdr_start & ~h_cont & frag_match;

  // ----------------------------------------
  // Message numbering
  // ----------------------------------------
  wire num_valid = (hdr_start & frag_init) | (start & acc_num);
  wire [`PMRC_NW-1:0] num_value = hdr_start ? h_num : num_field;
  wire num_skip = ~msg_retrieval | msg_dyn_group;

  pmrc_msgnum_tbl u_tbl (
    .clock(clock),
    .reset(reset),
    .chk_valid(num_valid),
    .chk_addr(msg_addr),
    .chk_num(num_value),
    .chk_skip(num_skip),
    .roll_max(ctrl_ff[`PMRC_C_MAX]),
    .missed(missed_pulse),
    .miss_first(miss_first),
    .miss_count(miss_count)
  );

  // ----------------------------------------
  // Fragment hold timer
  // ----------------------------------------
  wire tick = tick_cnt_ff == `PMRC_TICK_W'(TICK_CYCLES - 1);
  // abandon only after the full hold
  wire hold_out = open_ff & (hold_cnt_ff >= `PMRC_HOLD_W'(HOLD_TICKS));

  always_ff @(posedge clock) begin
    if (reset || !open_ff || frag_upd || tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + `PMRC_TICK_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !open_ff || frag_upd) begin
      hold_cnt_ff <= '0;
    end else if (tick && !hold_out) begin
      hold_cnt_ff <= hold_cnt_ff + `PMRC_HOLD_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      open_ff <= 1'b0;
    end else if (frag_upd) begin
      open_ff <= 1'b1;
    end else if (frag_end || hold_out) begin
      open_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      open_addr_ff <= '0;
      open_num_ff <= '0;
      exp_frag_ff <= `PMRC_F_FIRST;
    end else if (frag_upd) begin
      open_addr_ff <= msg_addr;
      open_num_ff <= h_num;
      exp_frag_ff <= frag_next;
    end
  end

  // ----------------------------------------
  // Word sequencing
  // ----------------------------------------
  wire body_word = word_valid & ~word_first & (state_ff == pmrc_pkg::PMRC_BODY) & text_ff;
  wire live_last = word_valid & word_last
                   & ((start & accept) | (~word_first & (state_ff == pmrc_pkg::PMRC_BODY)));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pmrc_pkg::PMRC_IDLE,
      pmrc_pkg::PMRC_BODY,
      pmrc_pkg::PMRC_SKIP: begin
        if (start) begin
          if (word_last) begin
            nxt_state = pmrc_pkg::PMRC_IDLE;
          end else begin
            nxt_state = accept ? pmrc_pkg::PMRC_BODY : pmrc_pkg::PMRC_SKIP;
          end
        end else if (word_valid && word_last) begin
          nxt_state = pmrc_pkg::PMRC_IDLE;
        end
      end
      default: begin
        nxt_state = pmrc_pkg::PMRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= pmrc_pkg::PMRC_IDLE;
      text_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        text_ff <= acc_text;
      end
    end
  end

  // ----------------------------------------
  // Characters
  // ----------------------------------------
  wire [`PMRC_CH_N:0] etx_run;
  wire [`PMRC_CH_N-1:0] keep_w;
  assign etx_run[0] = etx_seen_ff;
  // end-of-text drops this and later slots
  genvar gi;
  generate
    for (gi = 0; gi < `PMRC_CH_N; gi = gi + 1) begin : g_slot
      wire is_etx = word_data[gi*`PMRC_CH_W +: `PMRC_CH_W] == `PMRC_ETX;
      assign etx_run[gi+1] = etx_run[gi] | is_etx;
      assign keep_w[gi] = ~etx_run[gi+1];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset || start) begin
      etx_seen_ff <= 1'b0;
    end else if (body_word) begin
      etx_seen_ff <= etx_run[`PMRC_CH_N];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      char_valid <= 1'b0;
      char_data <= '0;
      char_keep <= '0;
    end else begin
      char_valid <= body_word;
      if (body_word) begin
        char_data <= word_data;
        char_keep <= keep_w;
      end
    end
  end

  // ----------------------------------------
  // Fragment check
  // ----------------------------------------
  pmrc_frag_sum u_sum (
    .clock(clock),
    .reset(reset),
    .sum_valid(hdr_start | body_word),
    .sum_first(hdr_start),
    .sum_word(word_data),
    .chk_value(chk_value)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      k_ff <= '0;
      chk_pend_ff <= 1'b0;
      check_err <= 1'b0;
    end else begin
      if (hdr_start) begin
        k_ff <= word_data[`PMRC_H_K];
      end
      chk_pend_ff <= (hdr_start | body_word) & word_last;
      check_err <= chk_pend_ff & (chk_value != k_ff);
    end
  end

  // ----------------------------------------
  // Event pulses
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      msg_accept <= 1'b0;
      msg_reject <= 1'b0;
      msg_done <= 1'b0;
      frag_err <= 1'b0;
      frag_abandon <= 1'b0;
      rate_ff <= pmrc_pkg::PMRC_R1600_2L;
    end else begin
      msg_accept <= start & accept;
      msg_reject <= start & ~accept;
      msg_done <= live_last;
      frag_err <= frag_bad;
      frag_abandon <= hold_out;
      if (start && accept) begin
        rate_ff <= pmrc_pkg::pmrc_rate_t'(rate_mode);
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  wire wr_ctrl = reg_wr & (reg_addr == `PMRC_REG_CTRL);
  wire wr_stat = reg_wr & (reg_addr == `PMRC_REG_STAT);
  wire [31:0] stat_word = {13'h0000, rate_ff, open_ff, aban_s_ff, kerr_s_ff, ferr_s_ff,
                           miss_s_ff, miss_count, miss_first};
  wire [31:0] rd_sel = (reg_addr == `PMRC_REG_CTRL) ? {23'h00_0000, ctrl_ff}
                     : (reg_addr == `PMRC_REG_STAT) ? stat_word
                     : (reg_addr == `PMRC_REG_CHK) ? {22'h00_0000, chk_value}
                     : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_ff <= `PMRC_CTRL_RST;
      reg_rdata <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[`PMRC_CTRL_W-1:0];
      end
      reg_rdata <= reg_rd ? rd_sel : '0;
    end
  end

  // Sticky flags, new event beats the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      miss_s_ff <= 1'b0;
      ferr_s_ff <= 1'b0;
      kerr_s_ff <= 1'b0;
      aban_s_ff <= 1'b0;
    end else begin
      miss_s_ff <= missed_pulse | (miss_s_ff & ~(wr_stat & reg_wdata[`PMRC_S_MISS]));
      ferr_s_ff <= frag_err | (ferr_s_ff & ~(wr_stat & reg_wdata[`PMRC_S_FERR]));
      kerr_s_ff <= check_err | (kerr_s_ff & ~(wr_stat & reg_wdata[`PMRC_S_KERR]));
      aban_s_ff <= frag_abandon | (aban_s_ff & ~(wr_stat & reg_wdata[`PMRC_S_ABAN]));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_text_last;
    (hdr_start || body_word) && word_last;
  endsequence
  sequence s_sum_judged;
    chk_pend_ff ##1 (check_err == $past(chk_value != k_ff));
  endsequence
  check_judge_a: assert property (s_text_last |=> s_sum_judged)
    else $error("fragment check not judged");
  short_ok_a: assert property (start && acc_short |=> msg_accept && !msg_reject)
    else $error("short message vector refused");
  frag_seq_a: assert property (frag_upd |=> open_ff && exp_frag_ff != `PMRC_F_INIT)
    else $error("fragment number sequence wrong");
  hold_min_a: assert property (frag_abandon |->
                               $past(hold_cnt_ff) >= `PMRC_HOLD_W'(HOLD_TICKS))
    else $error("fragment abandoned early");
  etx_drop_a: assert property (body_word && etx_run[1] |=> char_valid && char_keep == '0)
    else $error("text kept after end code");
  final_close_a: assert property (frag_end && !frag_upd |=> !open_ff)
    else $error("final fragment left open");
endmodule

// [dv/pmrc_enc_model.sv]
// Paging encoder stand-in that drives the received word stream
`include "pmrc_cfg.svh"
module pmrc_enc_model (
  input wire logic clock,
  output logic word_valid,
  output logic [20:0] word_data,
  output logic word_first,
  output logic word_last,
  output logic [`PMRC_AW-1:0] msg_addr,
  output logic [2:0] vector_type_code,
  output logic [1:0] short_msg_type,
  output logic [2:0] instruction_type,
  output logic msg_retrieval,
  output logic msg_dyn_group,
  output logic [`PMRC_NW-1:0] num_field,
  output logic [1:0] rate_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {word_valid, word_data, word_first, word_last, msg_addr, vector_type_code} = '0;
    {short_msg_type, instruction_type, msg_retrieval, msg_dyn_group, num_field} = '0;
    rate_mode = 2'h0;
  end
  // Sum of the three bit groups of one word
  function automatic logic [15:0] grp(input logic [20:0] w);
    return 16'(w[7:0]) + 16'(w[15:8]) + 16'(w[20:16]);
  endfunction
  function automatic logic [20:0] text_hdr(input logic c, input logic [1:0] f,
                                           input logic [5:0] n);
    logic [20:0] h;
    logic [15:0] s;
    h = {2'h0, n, f, c, 10'h000};
    s = grp(h);
    h[9:0] = ~s[9:0];
    return h;
  endfunction
  // retrieval and group flags per message
  task automatic set_msg(input logic [2:0] a, v, input logic [1:0] t, input logic [2:0] i,
                         input logic r, d, input logic [5:0] n, input logic [1:0] m);
    @(posedge clock);
    msg_addr <= a;
    vector_type_code <= v;
    short_msg_type <= t;
    instruction_type <= i;
    msg_retrieval <= r;
    msg_dyn_group <= d;
    num_field <= n;
    rate_mode <= m;
  endtask
  // Released data line shows the inverse of the last word
  task automatic send(input logic f, l, input logic [20:0] w);
    @(posedge clock);
    word_valid <= 1'b1;
    word_first <= f;
    word_last <= l;
    word_data <= w;
    @(posedge clock);
    word_valid <= 1'b0;
    word_first <= 1'b0;
    word_last <= 1'b0;
    word_data <= ~w;
    #1;
  endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the paging message rule checker
`include "pmrc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] vec;
    logic [1:0] styp;
    logic [2:0] ityp;
    logic [1:0] rate;
    logic acc;
  } pmrc_row_t;
  localparam int TICKS = 4;
  localparam int HOLD = 5;
  logic clock, reset, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic word_valid, word_first, word_last, msg_retrieval, msg_dyn_group;
  logic [20:0] word_data, char_data, h, hx, b1, b2;
  logic [`PMRC_AW-1:0] msg_addr;
  logic [2:0] vector_type_code, instruction_type;
  logic [1:0] short_msg_type, rate_mode;
  logic [`PMRC_NW-1:0] num_field;
  logic [`PMRC_CH_N-1:0] char_keep;
  logic char_valid, msg_accept, msg_reject, msg_done, missed_pulse;
  logic frag_err, check_err, frag_abandon;
  logic [15:0] s;
  int bad_count, n_compared, w;
  pmrc_row_t rows [9] = '{'{3'h3, 2'h0, 3'h0, 2'h0, 1'b1}, '{3'h4, 2'h0, 3'h0, 2'h1, 1'b1},
    '{3'h7, 2'h0, 3'h0, 2'h2, 1'b1}, '{3'h2, 2'h0, 3'h0, 2'h3, 1'b1},
    '{3'h5, 2'h0, 3'h0, 2'h0, 1'b1}, '{3'h0, 2'h0, 3'h0, 2'h1, 1'b1},
    '{3'h1, 2'h0, 3'h0, 2'h2, 1'b0}, '{3'h6, 2'h0, 3'h0, 2'h3, 1'b0},
    '{3'h2, 2'h1, 3'h0, 2'h0, 1'b0}};

  pmrc_msg_checker #(.TICK_CYCLES(TICKS), .HOLD_TICKS(HOLD)) dut (.clock, .reset,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .word_valid, .word_data,
    .word_first, .word_last, .msg_addr, .vector_type_code, .short_msg_type,
    .instruction_type, .msg_retrieval, .msg_dyn_group, .num_field, .rate_mode,
    .char_valid, .char_data, .char_keep, .msg_accept, .msg_reject, .msg_done,
    .missed_pulse, .frag_err, .check_err, .frag_abandon);
  pmrc_enc_model enc (.clock, .word_valid, .word_data, .word_first, .word_last,
    .msg_addr, .vector_type_code, .short_msg_type, .instruction_type, .msg_retrieval,
    .msg_dyn_group, .num_field, .rate_mode);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic num(input logic [2:0] a, input logic [5:0] n, input logic r, d, miss);
    enc.set_msg(a, 3'h3, 2'h0, 3'h0, r, d, n, 2'h0);
    enc.send(1'b1, 1'b1, 21'h0_0000);
    chk(missed_pulse, miss);
  endtask
  task automatic frag(input logic c, input logic [1:0] f, input logic [5:0] n, input logic e);
    enc.send(1'b1, 1'b1, enc.text_hdr(c, f, n));
    chk(frag_err, e);
  endtask
  task final_report;
    $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    final_report;
  end

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(`PMRC_REG_CTRL);
    chk(rd_val, 32'h0000_00FF);
    rd(`PMRC_REG_STAT);
    chk(rd_val, 32'h0000_0000);
    rd(8'h0C);
    chk(rd_val, 32'h0000_0000);
    foreach (rows[k]) begin
      enc.set_msg(3'h0, rows[k].vec, rows[k].styp, rows[k].ityp, 1'b0, 1'b0, 6'h00, rows[k].rate);
      enc.send(1'b1, 1'b1, enc.text_hdr(1'b0, 2'h3, 6'h00));
      chk(msg_accept, rows[k].acc);
      chk(msg_reject, !rows[k].acc);
      if (rows[k].acc) begin
        rd(`PMRC_REG_STAT);
        chk(rd_val[18:17], rows[k].rate);
      end
    end
    num(3'h1, 6'h00, 1'b1, 1'b0, 1'b0);
    num(3'h1, 6'h01, 1'b1, 1'b0, 1'b0);
    num(3'h1, 6'h04, 1'b1, 1'b0, 1'b1);
    rd(`PMRC_REG_STAT);
    chk(rd_val[12:0], 13'h1082);
    wr(`PMRC_REG_STAT, 32'h0000_1000);
    rd(`PMRC_REG_STAT);
    chk(rd_val[12], 1'b0);
    num(3'h1, 6'h09, 1'b0, 1'b0, 1'b0);
    num(3'h1, 6'h05, 1'b1, 1'b0, 1'b0);
    num(3'h1, 6'h1E, 1'b1, 1'b1, 1'b0);
    num(3'h1, 6'h06, 1'b1, 1'b0, 1'b0);
    wr(`PMRC_REG_CTRL, 32'h0000_00C7);
    num(3'h2, 6'h07, 1'b1, 1'b0, 1'b0);
    num(3'h2, 6'h00, 1'b1, 1'b0, 1'b0);
    num(3'h2, 6'h03, 1'b1, 1'b0, 1'b1);
    rd(`PMRC_REG_STAT);
    chk(rd_val[11:0], 12'h081);
    wr(`PMRC_REG_CTRL, 32'h0000_01FF);
    enc.set_msg(3'h3, 3'h1, 2'h0, 3'h0, 1'b0, 1'b0, 6'h00, 2'h0);
    enc.send(1'b1, 1'b1, 21'h0_0000);
    chk(msg_accept, 1'b1);
    // spare slot padded with end code
    b1 = {7'h03, 7'h42, 7'h41};
    b2 = {7'h45, 7'h44, 7'h43};
    h = {2'h0, 6'h00, 2'h3, 1'b0, 10'h000};
    s = enc.grp(h) + enc.grp(b1) + enc.grp(b2);
    h[9:0] = ~s[9:0];
    enc.set_msg(3'h4, 3'h5, 2'h0, 3'h0, 1'b0, 1'b0, 6'h00, 2'h0);
    for (int e = 0; e < 2; e++) begin
      hx = h;
      hx[0] = hx[0] ^ e[0];
      enc.send(1'b1, 1'b0, hx);
      chk(msg_accept, 1'b1);
      enc.send(1'b0, 1'b0, b1);
      chk(char_valid, 1'b1);
      chk(char_data, b1);
      chk(char_keep, 3'h3);
      enc.send(1'b0, 1'b1, b2);
      chk(char_keep, 3'h0);
      chk(msg_done, 1'b1);
      @(posedge clock);
      #1;
      chk(check_err, e[0]);
    end
    rd(`PMRC_REG_CHK);
    chk(rd_val, {22'h00_0000, h[9:0]});
    enc.set_msg(3'h5, 3'h5, 2'h0, 3'h0, 1'b0, 1'b0, 6'h00, 2'h0);
    frag(1'b1, 2'h3, 6'h09, 1'b0);
    rd(`PMRC_REG_STAT);
    chk(rd_val[16], 1'b1);
    frag(1'b1, 2'h0, 6'h09, 1'b0);
    frag(1'b1, 2'h1, 6'h09, 1'b0);
    frag(1'b1, 2'h0, 6'h09, 1'b1);
    frag(1'b1, 2'h3, 6'h09, 1'b0);
    frag(1'b1, 2'h0, 6'h0C, 1'b1);
    frag(1'b1, 2'h3, 6'h09, 1'b0);
    frag(1'b0, 2'h0, 6'h09, 1'b0);
    rd(`PMRC_REG_STAT);
    chk(rd_val[16], 1'b0);
    frag(1'b1, 2'h3, 6'h09, 1'b0);
    w = 0;
    while (frag_abandon !== 1'b1 && w < 200) begin
      @(posedge clock);
      #1;
      w++;
    end
    chk(w >= (HOLD - 1) * TICKS && w <= (HOLD + 1) * TICKS + 4, 1'b1);
    rd(`PMRC_REG_STAT);
    chk(rd_val[15], 1'b1);
    // Second reset in mid-run
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(`PMRC_REG_CTRL);
    chk(rd_val, 32'h0000_00FF);
    rd(`PMRC_REG_STAT);
    chk(rd_val, 32'h0000_0000);
    final_report;
  end
endmodule
